// >>> wts_checker.sv
// assertions on the timer select register and unit routing
module wts_checker
  import wts_pkg::*;
(
  input wire logic                     CLK,
  input wire logic                     RST_B,
  input wire logic [ADDR_W-1:0]        ADDR,
  input wire logic [7:0]               WDATA,
  input wire logic                     WR,
  input wire logic                     RD,
  input wire logic [7:0]               RDATA,
  input wire logic [TIMER_W-1:0]       PERIOD_TIMER_A,
  input wire logic [TIMER_W-1:0]       PERIOD_TIMER_B,
  input wire logic [TIMER_W-1:0]       PERIOD_TIMER_C,
  input wire logic                     PERIOD_TIMER_A_MATCH,
  input wire logic                     PERIOD_TIMER_B_MATCH,
  input wire logic                     PERIOD_TIMER_C_MATCH,
  input wire logic [NUM_UNITS*TIMER_W-1:0] UNIT_TIMER,
  input wire logic [NUM_UNITS-1:0]     UNIT_MATCH,
  input wire logic [NUM_UNITS-1:0]     UNIT_VALID
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  n_q;
  logic [7:0]  r_q;
  logic [39:0] e_q;
  function automatic logic [9:0] pk(input logic [1:0] s);
    case (s)
      SEL_PERIOD_TIMER_A: pk = {1'b1, PERIOD_TIMER_A_MATCH, PERIOD_TIMER_A};
      SEL_PERIOD_TIMER_B: pk = {1'b1, PERIOD_TIMER_B_MATCH, PERIOD_TIMER_B};
      SEL_PERIOD_TIMER_C: pk = {1'b1, PERIOD_TIMER_C_MATCH, PERIOD_TIMER_C};
      default:            pk = 10'h000;
    endcase
  endfunction
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      n_q <= 2'h0;
      r_q <= 8'h00;
      e_q <= 40'h0;
    end
    else
    begin
      n_q <= (n_q == 2'h3) ? n_q : n_q + 2'h1;
      r_q <= (WR && ADDR == WAVEFORM_TIMER_SELECT_OFFSET) ? WDATA : r_q;
      e_q <= {pk(r_q[7:6]), pk(r_q[5:4]), pk(r_q[3:2]), pk(r_q[1:0])};
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  AST_RD_DATA: assert property (n_q == 2'h3 && RD && ADDR == WAVEFORM_TIMER_SELECT_OFFSET
    |=> RDATA == $past(r_q)) else $error("read data differs from register");
  AST_RD_UNMAP: assert property (RD && ADDR != WAVEFORM_TIMER_SELECT_OFFSET
    |=> RDATA == UNMAPPED_READ_VALUE) else $error("unmapped read not zero");
  AST_RD_IDLE: assert property (!RD |=> RDATA == 8'h00) else $error("read data without read");
  AST_RST: assert property (n_q != 2'h3 |-> UNIT_VALID == 4'h0
    && RDATA == WAVEFORM_TIMER_SELECT_RESET) else $error("outputs not clear in reset");
  AST_U0: assert property (n_q == 2'h3 |-> {UNIT_VALID[0], UNIT_MATCH[0], UNIT_TIMER[7:0]}
    == e_q[9:0]) else $error("unit zero routing wrong");
  AST_U1: assert property (n_q == 2'h3 |-> {UNIT_VALID[1], UNIT_MATCH[1], UNIT_TIMER[15:8]}
    == e_q[19:10]) else $error("unit one routing wrong");
  AST_U2: assert property (n_q == 2'h3 |-> {UNIT_VALID[2], UNIT_MATCH[2], UNIT_TIMER[23:16]}
    == e_q[29:20]) else $error("unit two routing wrong");
  AST_U3: assert property (n_q == 2'h3 |-> {UNIT_VALID[3], UNIT_MATCH[3], UNIT_TIMER[31:24]}
    == e_q[39:30]) else $error("unit three routing wrong");
endmodule // wts_checker
bind wts_top wts_checker i_wts_checker (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .PERIOD_TIMER_A(PERIOD_TIMER_A),
  .PERIOD_TIMER_B(PERIOD_TIMER_B), .PERIOD_TIMER_C(PERIOD_TIMER_C),
  .PERIOD_TIMER_A_MATCH(PERIOD_TIMER_A_MATCH), .PERIOD_TIMER_B_MATCH(PERIOD_TIMER_B_MATCH),
  .PERIOD_TIMER_C_MATCH(PERIOD_TIMER_C_MATCH), .UNIT_TIMER(UNIT_TIMER),
  .UNIT_MATCH(UNIT_MATCH), .UNIT_VALID(UNIT_VALID));

// >>> wts_pkg.sv
// package for the waveform timer source selection block
// Function
// - each waveform unit chooses its clocking timer
// - each unit keeps its own separate selection
// - pool holds three 8-bit auto-reload timers
// - any unit runs from any pool timer
// - one shared software-written selection register
// - unit four field bits 7-6 coding
// - code 00 picks timer a, reset zero
package wts_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int         ADDR_W             = 4;
  localparam logic [3:0] WAVEFORM_TIMER_SELECT_OFFSET = 4'h0;
  localparam logic [7:0] WAVEFORM_TIMER_SELECT_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE          = 8'h00;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int NUM_UNITS  = 4;
  localparam int FIELD_W    = 2;
  localparam int TIMER_W    = 8;
  localparam int NUM_TIMERS = 3;
  localparam int CAPCOMP_ONE_TIMER_FIELD_LSB    = 0;
  localparam int CAPCOMP_TWO_TIMER_FIELD_LSB    = 2;
  localparam int PWM_UNIT_THREE_TIMER_FIELD_LSB = 4;
  localparam int PWM_UNIT_FOUR_TIMER_FIELD_LSB  = 6;

  // ---------------------------------------------------------------
  // timer codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_PERIOD_TIMER_A = 2'h0;
  localparam logic [1:0] SEL_PERIOD_TIMER_B = 2'h1;
  localparam logic [1:0] SEL_PERIOD_TIMER_C = 2'h2;
  localparam logic [1:0] SEL_RESERVED       = 2'h3;
endpackage

// >>> wts_sync.sv
// two flip-flop reset release synchroniser
module wts_sync
  import wts_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  output logic      rst_sync_b
);
  logic stage1_q;
  logic stage2_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end
    else
    begin
      stage1_q <= 1'b1;
      stage2_q <= stage1_q;
    end
  end

  assign rst_sync_b = stage2_q;
endmodule // wts_sync

// >>> wts_top.sv
// waveform timer source selection register and routing
module wts_top
  import wts_pkg::*;
(
  input  wire logic                             CLK,
  input  wire logic                             RST_B,
  input  wire logic [ADDR_W-1:0]                ADDR,
  input  wire logic [7:0]                       WDATA,
  input  wire logic                             WR,
  input  wire logic                             RD,
  output logic      [7:0]                       RDATA,
  input  wire logic [TIMER_W-1:0]               PERIOD_TIMER_A,
  input  wire logic [TIMER_W-1:0]               PERIOD_TIMER_B,
  input  wire logic [TIMER_W-1:0]               PERIOD_TIMER_C,
  input  wire logic                             PERIOD_TIMER_A_MATCH,
  input  wire logic                             PERIOD_TIMER_B_MATCH,
  input  wire logic                             PERIOD_TIMER_C_MATCH,
  output logic      [NUM_UNITS*TIMER_W-1:0]     UNIT_TIMER,
  output logic      [NUM_UNITS-1:0]             UNIT_MATCH,
  output logic      [NUM_UNITS-1:0]             UNIT_VALID
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_sync_b;

  wts_sync u_sync
  (
    .clk        (CLK),
    .rst_b      (RST_B),
    .rst_sync_b (rst_sync_b)
  );

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic [7:0] waveform_timer_select_q;
  logic [7:0] waveform_timer_select_d;
  logic [7:0] rdata_d;
  logic       hit;
  logic       wr_hit;

  assign hit    = (ADDR == WAVEFORM_TIMER_SELECT_OFFSET);
  assign wr_hit = WR && hit;
  assign waveform_timer_select_d = wr_hit ? WDATA : waveform_timer_select_q;
  assign rdata_d = (RD && hit) ? waveform_timer_select_q :
                   RD ? UNMAPPED_READ_VALUE : 8'h00;

  always_ff @(posedge CLK or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      waveform_timer_select_q <= WAVEFORM_TIMER_SELECT_RESET;
    else
      waveform_timer_select_q <= waveform_timer_select_d;
  end

  always_ff @(posedge CLK or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      RDATA <= 8'h00;
    else
      RDATA <= rdata_d;
  end

  // ---------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------
  logic [FIELD_W-1:0] capcomp_one_timer_field;
  logic [FIELD_W-1:0] capcomp_two_timer_field;
  logic [FIELD_W-1:0] pwm_unit_three_timer_field;
  logic [FIELD_W-1:0] pwm_unit_four_timer_field;
  logic [FIELD_W-1:0] unit_sel [NUM_UNITS];

  assign capcomp_one_timer_field =
    waveform_timer_select_q[CAPCOMP_ONE_TIMER_FIELD_LSB +: FIELD_W];
  assign capcomp_two_timer_field =
    waveform_timer_select_q[CAPCOMP_TWO_TIMER_FIELD_LSB +: FIELD_W];
  assign pwm_unit_three_timer_field =
    waveform_timer_select_q[PWM_UNIT_THREE_TIMER_FIELD_LSB +: FIELD_W];
  assign pwm_unit_four_timer_field =
    waveform_timer_select_q[PWM_UNIT_FOUR_TIMER_FIELD_LSB +: FIELD_W];
  assign unit_sel[0] = capcomp_one_timer_field;
  assign unit_sel[1] = capcomp_two_timer_field;
  assign unit_sel[2] = pwm_unit_three_timer_field;
  assign unit_sel[3] = pwm_unit_four_timer_field;

  // ---------------------------------------------------------------
  // per-unit routing
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_UNITS; g++)
    begin : g_unit
      // one independent selector per unit, pool
      wts_unit_mux u_mux
      (
        .clk     (CLK),
        .rst_b   (rst_sync_b),
        .sel     (unit_sel[g]),
        .timer_a (PERIOD_TIMER_A),
        .timer_b (PERIOD_TIMER_B),
        .timer_c (PERIOD_TIMER_C),
        .match_a (PERIOD_TIMER_A_MATCH),
        .match_b (PERIOD_TIMER_B_MATCH),
        .match_c (PERIOD_TIMER_C_MATCH),
        .timer_q (UNIT_TIMER[g*TIMER_W +: TIMER_W]),
        .match_q (UNIT_MATCH[g]),
        .valid_q (UNIT_VALID[g])
      );
    end
  endgenerate
endmodule // wts_top

// >>> wts_top_bench.sv
// self-checking bench of the timer select block
module wts_top_bench
  import wts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        ma = 1'b1, mb = 1'b0, mc = 1'b0;
  logic [3:0]  addr = 4'h0, um, uv;
  logic [7:0]  wdata = 8'h00, ta = 8'h11, tb = 8'h22, tc = 8'h33, rdata;
  logic [31:0] ut;
  int          n_mismatch = 0, total_checks = 0, cyc = 0;
  wts_top i_wts_top (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PERIOD_TIMER_A(ta), .PERIOD_TIMER_B(tb), .PERIOD_TIMER_C(tc),
    .PERIOD_TIMER_A_MATCH(ma), .PERIOD_TIMER_B_MATCH(mb), .PERIOD_TIMER_C_MATCH(mc),
    .UNIT_TIMER(ut), .UNIT_MATCH(um), .UNIT_VALID(uv));
  always #20 clk = ~clk;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      finish_test;
    end
  end
  task automatic chk(logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(32'(rdata), 32'(e));
  endtask
  function automatic logic [9:0] ex(logic [1:0] c);
    case (c)
      SEL_PERIOD_TIMER_A: ex = {1'b1, ma, ta};
      SEL_PERIOD_TIMER_B: ex = {1'b1, mb, tb};
      SEL_PERIOD_TIMER_C: ex = {1'b1, mc, tc};
      default:            ex = 10'h000;
    endcase
  endfunction
  task automatic units(logic [7:0] w);
    repeat (2) @(posedge clk);
    #1;
    for (int u = 0; u < 4; u++)
      chk(32'({uv[u], um[u], ut[8*u+:8]}), 32'(ex(w[2*u+:2])));
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(4'h0, 8'h00);
    units(8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(4'h0, 8'(8'h55 * c));
      rd_reg(4'h0, 8'(8'h55 * c));
      units(8'(8'h55 * c));
    end
    @(posedge clk);
    ta <= 8'h5a;
    mb <= 1'b1;
    wr_reg(4'h0, 8'he4);
    units(8'he4);
    wr_reg(4'h3, 8'hff);
    units(8'he4);
    rd_reg(4'h3, UNMAPPED_READ_VALUE);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(4'h0, WAVEFORM_TIMER_SELECT_RESET);
    units(8'h00);
    finish_test;
  end
endmodule // wts_top_bench

// >>> wts_unit_mux.sv
// per-unit timer source selector with registered output
module wts_unit_mux
  import wts_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic [FIELD_W-1:0] sel,
  input  wire logic [TIMER_W-1:0] timer_a,
  input  wire logic [TIMER_W-1:0] timer_b,
  input  wire logic [TIMER_W-1:0] timer_c,
  input  wire logic               match_a,
  input  wire logic               match_b,
  input  wire logic               match_c,
  output logic      [TIMER_W-1:0] timer_q,
  output logic                    match_q,
  output logic                    valid_q
);
  // ---------------------------------------------------------------
  // selection
  // ---------------------------------------------------------------
  logic [TIMER_W-1:0] timer_d;
  logic               match_d;
  logic               valid_d;

  assign timer_d = (sel == SEL_PERIOD_TIMER_B) ? timer_b :
                   (sel == SEL_PERIOD_TIMER_C) ? timer_c :
                   (sel == SEL_PERIOD_TIMER_A) ? timer_a : '0;
  assign match_d = (sel == SEL_PERIOD_TIMER_B) ? match_b :
                   (sel == SEL_PERIOD_TIMER_C) ? match_c :
                   (sel == SEL_PERIOD_TIMER_A) ? match_a : 1'b0;
  assign valid_d = (sel != SEL_RESERVED);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      timer_q <= '0;
      match_q <= 1'b0;
      valid_q <= 1'b0;
    end
    else
    begin
      timer_q <= timer_d;
      match_q <= match_d;
      valid_q <= valid_d;
    end
  end
endmodule // wts_unit_mux
